//--- inc/bwc_pkg.sv
package bwc_pkg;

    // =========================================================
    // Register map (byte addresses, one word each)
    localparam logic [11:0] OFS_INPUT   = 12'h000;
    localparam logic [11:0] OFS_SUM_LO  = 12'h004;
    localparam logic [11:0] OFS_SUM_HI  = 12'h008;
    localparam logic [11:0] OFS_POLYCTL = 12'h00C;
    localparam logic [11:0] OFS_STATUS  = 12'h010;

    // =========================================================
    // Fields and reset values
    localparam int          POLYNOMIAL_SELECT_SEL_BIT   = 0;
    localparam int          STAT_PEND_BIT  = 0;
    localparam int          STAT_FULL_BIT  = 1;
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [15:0] RST_SUM        = 16'h0000;

    // =========================================================
    // Generator constants
    localparam logic [15:0] POLYNOMIAL_SELECT_CCITT     = 16'h1021;
    localparam logic [15:0] POLYNOMIAL_SELECT_CRC16     = 16'h8005;

    // =========================================================
    // Buffer shape
    localparam int          FIFO_WIDTH     = 8;
    localparam int          FIFO_DEPTH     = 4;

endpackage

//--- inc/bwc_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bwc_stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- logic/bwc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bwc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  empty,
    output logic                  full
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign empty     = (cnt_r == '0);
    assign full      = (cnt_r == (AW+1)'(DEPTH));
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_r[rptr_r];
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;

    // =========================================================
    // Storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (push) begin
            mem_r[wptr_r] <= in_data;
        end
    end

    // =========================================================
    // Pointers and count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
        end else begin
            if (push) begin
                wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

//--- logic/bwc_crc16.sv
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bwc_crc16 (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    // =========================================================
    // Declarations
    logic [7:0]  input_byte_r;
    logic [15:0] running_checksum_r;
    logic        polynomial_select_r;
    logic [31:0] prdata_r;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit;
    logic        in_wr;
    logic        fifo_empty;
    logic        fifo_full;
    logic [15:0] fold_nxt;
    logic [15:0] polynomial_select_val;
    logic        fold_valid;
    logic        fold_ready;
    logic [7:0]  fold_byte;

    bwc_stream_if feed ();

    assign wr_acc = psel && penable && pwrite && pready;
    assign rd_acc = psel && penable && !pwrite;
    assign hit    = (paddr == bwc_pkg::OFS_INPUT)   || (paddr == bwc_pkg::OFS_SUM_LO) ||
                    (paddr == bwc_pkg::OFS_SUM_HI)  || (paddr == bwc_pkg::OFS_POLYCTL) ||
                    (paddr == bwc_pkg::OFS_STATUS);
    assign in_wr  = wr_acc && (paddr == bwc_pkg::OFS_INPUT) && pstrb[0];

    // =========================================================
    // APB answer: input writes wait while the buffer is full
    assign pready  = !(psel && pwrite && (paddr == bwc_pkg::OFS_INPUT) && !feed.ready);
    assign pslverr = psel && penable && pready && !hit;
    assign prdata  = prdata_r;

    // =========================================================
    // Byte buffer between the bus and the folding logic
    assign feed.valid = in_wr;
    assign feed.data  = pwdata[7:0];

    bwc_fifo #(
        .WIDTH (bwc_pkg::FIFO_WIDTH),
        .DEPTH (bwc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (feed.valid),
        .in_ready  (feed.ready),
        .in_data   (feed.data),
        .out_valid (fold_valid),
        .out_ready (fold_ready),
        .out_data  (fold_byte),
        .empty     (fifo_empty),
        .full      (fifo_full)
    );

    // A checksum write holds off folding so the load is never overwritten
    assign fold_ready = !(wr_acc && ((paddr == bwc_pkg::OFS_SUM_LO) ||
                                     (paddr == bwc_pkg::OFS_SUM_HI)));

    // =========================================================
    // Eight bit steps unrolled in one cycle
    always_comb begin
        logic [15:0] t;
        t        = '0;
        polynomial_select_val = polynomial_select_r ? bwc_pkg::POLYNOMIAL_SELECT_CRC16
                                       : bwc_pkg::POLYNOMIAL_SELECT_CCITT;
        t = running_checksum_r ^ {fold_byte, 8'h00};
        for (int b = 0; b < 8; b++) begin
            if (t[15]) begin
                t = {t[14:0], 1'b0} ^ polynomial_select_val;
            end else begin
                t = {t[14:0], 1'b0};
            end
        end
        fold_nxt = t;
    end

    // =========================================================
    // Input byte register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_byte_r <= bwc_pkg::RST_BYTE;
        end else if (in_wr) begin
            input_byte_r <= pwdata[7:0];
        end
    end

    // =========================================================
    // Running checksum
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_checksum_r <= bwc_pkg::RST_SUM;
        end else if (wr_acc && paddr == bwc_pkg::OFS_SUM_LO && pstrb[0]) begin
            running_checksum_r[7:0] <= pwdata[7:0];
        end else if (wr_acc && paddr == bwc_pkg::OFS_SUM_HI && pstrb[0]) begin
            running_checksum_r[15:8] <= pwdata[7:0];
        end else if (fold_valid && fold_ready) begin
            running_checksum_r <= fold_nxt;
        end
    end

    // =========================================================
    // Polynomial control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            polynomial_select_r <= 1'b0;
        end else if (wr_acc && paddr == bwc_pkg::OFS_POLYCTL && pstrb[0]) begin
            polynomial_select_r <= pwdata[bwc_pkg::POLYNOMIAL_SELECT_SEL_BIT];
        end
    end

    // =========================================================
    // Read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                bwc_pkg::OFS_INPUT:   prdata_r <= {24'h000000, input_byte_r};
                bwc_pkg::OFS_SUM_LO:  prdata_r <= {24'h000000, running_checksum_r[7:0]};
                bwc_pkg::OFS_SUM_HI:  prdata_r <= {24'h000000, running_checksum_r[15:8]};
                bwc_pkg::OFS_POLYCTL: prdata_r <= {31'h0000_0000, polynomial_select_r};
                bwc_pkg::OFS_STATUS:  prdata_r <= {30'h0000_0000, fifo_full, !fifo_empty};
                default:              prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // =========================================================
    // Checks
    AST_FOLD_CCITT_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        (fold_valid && fold_ready && !polynomial_select_r && running_checksum_r == 16'h0000
         && fold_byte == 8'h01) |=> running_checksum_r == 16'h1021)
        else $error("CCITT fold of 01H from zero wrong");
    AST_FOLD_CRC16_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        (fold_valid && fold_ready && polynomial_select_r && running_checksum_r == 16'h0000
         && fold_byte == 8'h01) |=> running_checksum_r == 16'h8005)
        else $error("CRC16 fold of 01H from zero wrong");
    AST_FOLD_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
        (fold_valid && fold_ready) |=> running_checksum_r == $past(fold_nxt))
        else $error("Fold not stored in one cycle");
    AST_FOLD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (fold_valid && fold_ready && running_checksum_r == 16'h0000 && fold_byte == 8'h00)
        |=> running_checksum_r == 16'h0000)
        else $error("Zero byte from zero changed checksum");
    AST_LOAD_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == bwc_pkg::OFS_SUM_LO && pstrb[0])
        |=> running_checksum_r[7:0] == $past(pwdata[7:0]))
        else $error("Low checksum load lost");
    AST_LOAD_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == bwc_pkg::OFS_SUM_HI && pstrb[0])
        |=> running_checksum_r[15:8] == $past(pwdata[7:0]))
        else $error("High checksum load lost");
    AST_INPUT_QUEUED: assert property (@(posedge pclk) disable iff (!presetn)
        in_wr |=> !fifo_empty)
        else $error("Input write not queued");
    AST_CTL_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && paddr == bwc_pkg::OFS_POLYCTL) |-> prdata[31:1] == 31'h0000_0000)
        else $error("Control upper bits not zero");
    AST_STABLE_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        (!fold_valid && !wr_acc) |=> $stable(running_checksum_r))
        else $error("Checksum changed without cause");
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;

    // =========================================================
    // Signals and reference data
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] q;
    logic [65:0] exp_q[$];
    int          err_total;
    int          tests_run;
    logic [15:0] sum;
    logic        polynomial_select;
    logic [7:0]  b;
    logic [15:0] tbl[2][8] = '{'{16'h0000, 16'h1021, 16'h2042, 16'h3063,
                                 16'h4084, 16'h50A5, 16'h60C6, 16'h70E7},
                               '{16'h0000, 16'h8005, 16'h800F, 16'h000A,
                                 16'h801B, 16'h001E, 16'h0014, 16'h8011}};
    logic [15:0] seq_sum[2]  = '{16'hD0FA, 16'h5C43};
    logic [7:0]  seq_in[4]   = '{8'h78, 8'h56, 8'h34, 8'h12};

    bwc_crc16 DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
                   .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // =========================================================
    // Checking
    task automatic finish_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] seen, input logic [32:0] want);
        tests_run++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] %0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // Oldest note is matched against each completed transfer
    always @(posedge pclk) begin
        logic [65:0] e;
        if (psel && penable && pready) begin
            e = exp_q.pop_front();
            chk({pslverr, prdata} & e[32:0], e[65:33] & e[32:0]);
        end
    end

    function automatic logic [15:0] fold(logic [15:0] s, logic [7:0] d, logic p);
        s = s ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            s = s[15] ? ({s[14:0], 1'b0} ^ (p ? 16'h8005 : 16'h1021)) : {s[14:0], 1'b0};
        end
        return s;
    endfunction

    // =========================================================
    // Bus tasks
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [32:0] ev, input logic [32:0] em);
        exp_q.push_back({ev, em});
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i <= 40; i++) begin
            if (i == 40) begin
                err_total++;
                finish_test();
            end
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 33'h0, 33'h100000000);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] v);
        xfer(1'b0, a, 32'h0, {1'b0, v}, 33'h1FFFFFFFF);
    endtask

    task automatic sumchk(input logic [15:0] v);
        for (int i = 0; i <= 20; i++) begin
            if (i == 20) begin
                err_total++;
                finish_test();
            end
            xfer(1'b0, bwc_pkg::OFS_STATUS, 32'h0, 33'h0, 33'h0);
            if (q[bwc_pkg::STAT_PEND_BIT] === 1'b0) break;
        end
        rd(bwc_pkg::OFS_SUM_HI, {24'h0, v[15:8]});
        rd(bwc_pkg::OFS_SUM_LO, {24'h0, v[7:0]});
    endtask

    task automatic restart(input logic p);
        wr(bwc_pkg::OFS_POLYCTL, {31'h0, p});
        wr(bwc_pkg::OFS_SUM_LO, 32'h0);
        wr(bwc_pkg::OFS_SUM_HI, 32'h0);
    endtask

    // =========================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        err_total = 0;
        tests_run = 0;
        void'($urandom(32'h7D16F381));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) rd(12'(i * 4), 32'h0);
        wr(bwc_pkg::OFS_POLYCTL, 32'hFF);
        rd(bwc_pkg::OFS_POLYCTL, 32'h1);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 8; k++) begin
                restart(1'(p));
                wr(bwc_pkg::OFS_INPUT, 32'(k));
                sumchk(tbl[p][k]);
            end
            restart(1'(p));
            for (int k = 0; k < 4; k++) wr(bwc_pkg::OFS_INPUT, {24'h0, seq_in[k]});
            sumchk(seq_sum[p]);
        end
        repeat (6) begin
            polynomial_select = 1'($urandom);
            sum = 16'($urandom);
            wr(bwc_pkg::OFS_POLYCTL, {31'h0, polynomial_select});
            wr(bwc_pkg::OFS_SUM_LO, {24'h0, sum[7:0]});
            wr(bwc_pkg::OFS_SUM_HI, {24'h0, sum[15:8]});
            sumchk(sum);
            repeat (5) begin
                b = 8'($urandom);
                wr(bwc_pkg::OFS_INPUT, {24'h0, b});
                sum = fold(sum, b, polynomial_select);
            end
            rd(bwc_pkg::OFS_INPUT, {24'h0, b});
            sumchk(sum);
        end
        xfer(1'b0, 12'h020, 32'h0, {1'b1, 32'h0}, 33'h1FFFFFFFF);
        xfer(1'b1, 12'h020, 32'hFF, {1'b1, 32'h0}, 33'h100000000);
        sumchk(sum);
        finish_test();
    end

endmodule
`default_nettype wire
